/* File: include/splk_pkg.sv */
// Constants, types and helpers of the sector protection lock logic.
//
// Contract
// (RL1) Pin high, lock set: status write only clears lock, sectors untouched.
// (RL2) Host repeats the status write after lock reads 0 for a global op.
// (RL3) Lock clear, status write 00h: unprotect all sectors, lock stays 0.
// (RL4) Lock clear, status write 7Fh: protect all sectors, lock stays 0.
// (RL5) Lock clear, status write FFh: protect all sectors and set lock.
// (RL6) Write 0Fh with pin high clears lock without global operation.
// (RL7) Write F0h sets lock from 0 to 1, sectors untouched.
// (RL8) Only bit 7 is stored; bits 5..2 only select the global operation.
// (RL9) Status read bits 4..2 show pin level and protection summary.
// (RL10) Host reads a sector: opcode 3Ch then three address bytes.
// (RL11) After last address bit, output repeats FFh if protected, else 00h.
// (RL12) Above rated clock the host drops the first byte, reads two.
// (RL13) Chip select high ends the read at any bit and floats output.
// (RL14) Protection read data carries nothing about the pin level.
// (RL15) Pin low and lock set: hardware lock, commands ignored, all frozen.
// (RL16) A write that clears the lock performs no global operation.
// (RL17) Pin high and lock set: protect and unprotect sector rejected.
// (RL18) A write raising the lock also runs the selected global operation.
// (RL19) A sector is protected exactly when its register holds 1.
// (RL20) Lock clear: sector commands and global ops accepted, lock may rise.
// (RL21) With pin held low a set lock only clears through power cycle.
// (RL22) Reset: lock bit 0, every sector protection register 1.
`default_nettype none
package splk_pkg;
   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int SECTOR_NUM = 16;
   localparam int SEC_W = 4;
   localparam int SEC_LSB = 16;
   localparam logic [1:0] ADDR_LAST = 2'h2;

   // ------------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------------
   localparam logic [7:0] OPC_STAT_WR = 8'h01;
   localparam logic [7:0] OPC_RD_STAT = 8'h05;
   localparam logic [7:0] OPC_PROT = 8'h36;
   localparam logic [7:0] OPC_UNPROT = 8'h39;
   localparam logic [7:0] OPC_RD_PROT = 8'h3C;

   // ------------------------------------------------------------------
   // Status byte 1 fields and global operation codes
   // ------------------------------------------------------------------
   localparam int STAT_LOCK_BIT = 7;
   localparam int STAT_WP_BIT = 4;
   localparam int STAT_SUM_HI = 3;
   localparam int STAT_SUM_LO = 2;
   localparam int GLOB_HI = 5;
   localparam int GLOB_LO = 2;
   localparam logic [3:0] GLOB_UNPROT = 4'h0;
   localparam logic [3:0] GLOB_PROT = 4'hF;
   localparam logic [1:0] SUM_NONE = 2'h0;
   localparam logic [1:0] SUM_SOME = 2'h1;
   localparam logic [1:0] SUM_ALL = 2'h3;
   localparam logic [7:0] STAT_RST = 8'h0C;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic LOCK_RST = 1'b0;
   localparam logic PROT_RST = 1'b1;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OPCODE = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h2,
      ST_OUT = 3'h3,
      ST_IGNORE = 3'h6
   } splk_state_type;

   typedef enum logic [1:0] {
      KIND_STAT_WR = 2'h0,
      KIND_PROT = 2'h1,
      KIND_UNPROT = 2'h2
   } splk_kind_type;

   // Sector number from a 24-bit byte address
   function automatic logic [SEC_W-1:0] sector_of(input logic [23:0] a);
      sector_of = a[SEC_LSB+SEC_W-1:SEC_LSB];
   endfunction
endpackage
`default_nettype wire

/* File: rtl/splk_prot_array.sv */
// Bank of per-sector protection registers with global and single updates.
`default_nettype none
module splk_prot_array
   import splk_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Update strobes
   input wire logic glob_set,
   input wire logic glob_clr,
   input wire logic one_set,
   input wire logic one_clr,
   input wire logic [SEC_W-1:0] sel,
   // Register contents
   output logic [SECTOR_NUM-1:0] prot
);
   // ------------------------------------------------------------------
   // One register per sector
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < SECTOR_NUM; i++) begin : g_sec
         logic prot_reg;
         logic hit;
         assign hit = (sel == SEC_W'(i));
         // Global updates cover every sector, single ones the selected one
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               prot_reg <= PROT_RST; // RL22
            end else if (glob_set || (one_set && hit)) begin
               prot_reg <= 1'b1;
            end else if (glob_clr || (one_clr && hit)) begin
               prot_reg <= 1'b0;
            end
         end
         assign prot[i] = prot_reg; // RL19
      end
   endgenerate
endmodule
`default_nettype wire

/* File: rtl/splk_lock_top.sv */
// Serial front end and lock control of the sector protection logic.
`default_nettype none
module splk_lock_top
   import splk_pkg::*;
(
   // Core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // Write-protect pin
   input wire logic wp_n,
   // Lock state
   output logic protection_regs_lock_bit,
   output logic hw_locked,
   output logic sw_locked,
   output logic cmd_ignored,
   // Status and protection
   output logic [7:0] status_byte1,
   output logic [SECTOR_NUM-1:0] sector_protected
);
   // ------------------------------------------------------------------
   // Declarations, link domain
   // ------------------------------------------------------------------
   logic frame_rst_n;
   splk_state_type st_reg;
   splk_state_type st_next;
   logic [2:0] bit_cnt_reg;
   logic [1:0] byte_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] byte_in;
   logic byte_done;
   logic [7:0] opcode_reg;
   logic [23:0] addr_reg;
   logic rd_stat_reg;
   logic post_req;
   logic req_tgl_reg;
   splk_kind_type hold_kind_reg;
   logic [7:0] hold_data_reg;
   logic [SEC_W-1:0] hold_sec_reg;
   logic [SECTOR_NUM-1:0] prot_k1_reg;
   logic [SECTOR_NUM-1:0] prot_k2_reg;
   logic [7:0] stat_k1_reg;
   logic [7:0] stat_k2_reg;
   logic [7:0] out_byte;
   logic so_reg;
   logic so_oe_reg;

   // ------------------------------------------------------------------
   // Declarations, core domain
   // ------------------------------------------------------------------
   logic wp_s1_reg;
   logic wp_s2_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic req_s1_reg;
   logic req_s2_reg;
   logic req_s3_reg;
   logic new_req;
   logic pending_reg;
   logic exec;
   splk_kind_type kind_reg;
   logic [7:0] data_reg;
   logic [SEC_W-1:0] sec_reg;
   logic hw_lock;
   logic lock_reg;
   logic lock_next;
   logic glob_set;
   logic glob_clr;
   logic one_set;
   logic one_clr;
   logic ignored;
   logic [3:0] glob_sel;
   logic [SECTOR_NUM-1:0] prot;
   logic [1:0] summary;
   logic [7:0] status_next;
   logic [7:0] status_reg;
   logic hw_locked_reg;
   logic sw_locked_reg;
   logic ignored_reg;

   // ------------------------------------------------------------------
   // Link domain: frame reset and bit framing
   // ------------------------------------------------------------------
   // Chip select high ends the frame at once, at any bit position
   assign frame_rst_n = arst_n & ~cs_n; // RL13

   // Incoming byte including the bit sampled on this edge
   assign byte_in = {shift_reg, si};
   assign byte_done = (bit_cnt_reg == 3'h7);

   // Bit counter and input shifter, sampled on the rising edge
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_reg <= 3'h0;
         shift_reg <= 7'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg <= byte_in[6:0];
      end
   end

   // ------------------------------------------------------------------
   // Link domain: command sequencer
   // ------------------------------------------------------------------
   // Next state on each completed byte
   always_comb begin
      st_next = st_reg;
      if (byte_done) begin
         unique case (st_reg)
            ST_OPCODE: begin
               unique case (byte_in)
                  OPC_STAT_WR: st_next = ST_DATA;
                  OPC_PROT,
                  OPC_UNPROT,
                  OPC_RD_PROT: st_next = ST_ADDR;
                  OPC_RD_STAT: st_next = ST_OUT;
                  default: st_next = ST_IGNORE;
               endcase
            end
            ST_ADDR: begin
               if (byte_cnt_reg == ADDR_LAST) begin
                  // Read of a sector starts output after the last address
                  if (opcode_reg == OPC_RD_PROT) begin
                     st_next = ST_OUT; // RL11
                  end else begin
                     st_next = ST_IGNORE;
                  end
               end
            end
            ST_DATA: st_next = ST_IGNORE; // Extra data bytes are dropped
            ST_OUT: st_next = ST_OUT;
            ST_IGNORE: st_next = ST_IGNORE;
            default: st_next = ST_IGNORE;
         endcase
      end
   end

   // State register, restarted by every frame
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         st_reg <= ST_OPCODE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Opcode, address bytes and read kind
   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         opcode_reg <= 8'h00;
         addr_reg <= 24'h000000;
         byte_cnt_reg <= 2'h0;
         rd_stat_reg <= 1'b0;
      end else if (byte_done) begin
         if (st_reg == ST_OPCODE) begin
            opcode_reg <= byte_in;
            rd_stat_reg <= (byte_in == OPC_RD_STAT);
         end else if (st_reg == ST_ADDR) begin
            addr_reg <= {addr_reg[15:0], byte_in};
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Link domain: command hand-off
   // ------------------------------------------------------------------
   // A write command is posted once its last byte is complete
   assign post_req = byte_done &&
      ((st_reg == ST_DATA) ||
       ((st_reg == ST_ADDR) && (byte_cnt_reg == ADDR_LAST) &&
        (opcode_reg != OPC_RD_PROT)));

   // Toggle and held words survive the frame end for the core to take
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         req_tgl_reg <= 1'b0;
         hold_kind_reg <= KIND_STAT_WR;
         hold_data_reg <= 8'h00;
         hold_sec_reg <= '0;
      end else if (post_req) begin
         req_tgl_reg <= ~req_tgl_reg;
         hold_data_reg <= byte_in;
         hold_sec_reg <= sector_of({addr_reg[15:0], byte_in});
         if (st_reg == ST_DATA) begin
            hold_kind_reg <= KIND_STAT_WR;
         end else if (opcode_reg == OPC_PROT) begin
            hold_kind_reg <= KIND_PROT;
         end else begin
            hold_kind_reg <= KIND_UNPROT;
         end
      end
   end

   // ------------------------------------------------------------------
   // Link domain: read data
   // ------------------------------------------------------------------
   // Protection and status levels brought over from the core clock
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         prot_k1_reg <= {SECTOR_NUM{PROT_RST}};
         prot_k2_reg <= {SECTOR_NUM{PROT_RST}};
         stat_k1_reg <= STAT_RST;
         stat_k2_reg <= STAT_RST;
      end else begin
         prot_k1_reg <= prot;
         prot_k2_reg <= prot_k1_reg;
         stat_k1_reg <= status_reg;
         stat_k2_reg <= stat_k1_reg;
      end
   end

   // Sector read repeats all ones or all zeros, never the pin level
   always_comb begin
      if (rd_stat_reg) begin
         out_byte = stat_k2_reg; // RL9
      end else begin
         out_byte = {8{prot_k2_reg[sector_of(addr_reg)]}}; // RL11 RL14
      end
   end

   // Output shifted on the falling edge, most significant bit first
   always_ff @(negedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_reg <= 1'b0;
         so_oe_reg <= 1'b0; // RL13
      end else if (st_reg == ST_OUT) begin
         so_reg <= out_byte[~bit_cnt_reg]; // RL11
         so_oe_reg <= 1'b1;
      end
   end

   assign so_o = so_reg;
   assign so_oe = so_oe_reg;

   // ------------------------------------------------------------------
   // Core domain: synchronisers
   // ------------------------------------------------------------------
   // Pins and the request toggle pass two flops before use
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_s1_reg <= 1'b1;
         wp_s2_reg <= 1'b1;
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         wp_s1_reg <= wp_n;
         wp_s2_reg <= wp_s1_reg;
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   assign new_req = req_s2_reg ^ req_s3_reg;

   // ------------------------------------------------------------------
   // Core domain: pending command
   // ------------------------------------------------------------------
   // Held words are stable long before the toggle gets through
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         kind_reg <= KIND_STAT_WR;
         data_reg <= 8'h00;
         sec_reg <= '0;
      end else if (new_req) begin
         kind_reg <= hold_kind_reg;
         data_reg <= hold_data_reg;
         sec_reg <= hold_sec_reg;
      end
   end

   // Command runs once chip select is seen high; a new one wins
   assign exec = pending_reg & cs_s2_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= new_req | (pending_reg & ~exec);
      end
   end

   // ------------------------------------------------------------------
   // Core domain: lock and protection decode
   // ------------------------------------------------------------------
   assign hw_lock = lock_reg & ~wp_s2_reg; // RL15
   assign glob_sel = data_reg[GLOB_HI:GLOB_LO]; // RL8

   // Decide the effect of the command being executed
   always_comb begin
      lock_next = lock_reg;
      glob_set = 1'b0;
      glob_clr = 1'b0;
      one_set = 1'b0;
      one_clr = 1'b0;
      ignored = 1'b0;
      if (exec) begin
         unique case (kind_reg)
            KIND_STAT_WR: begin
               if (hw_lock) begin
                  ignored = 1'b1; // RL15 RL21
               end else if (lock_reg) begin
                  // Soft lock: only the lock bit falls
                  lock_next = 1'b0; // RL1 RL6 RL16
               end else begin
                  lock_next = data_reg[STAT_LOCK_BIT]; // RL8 RL7 RL20
                  glob_set = (glob_sel == GLOB_PROT); // RL4 RL5 RL18
                  glob_clr = (glob_sel == GLOB_UNPROT); // RL3 RL18
               end
            end
            KIND_PROT: begin
               if (lock_reg) begin
                  ignored = 1'b1; // RL17 RL15
               end else begin
                  one_set = 1'b1; // RL20
               end
            end
            KIND_UNPROT: begin
               if (lock_reg) begin
                  ignored = 1'b1; // RL17 RL15
               end else begin
                  one_clr = 1'b1; // RL20
               end
            end
            default: ignored = 1'b1;
         endcase
      end
   end

   // Lock bit, cleared only by reset or a write with the pin high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_reg <= LOCK_RST; // RL22 RL21
      end else begin
         lock_reg <= lock_next;
      end
   end

   // Sector protection registers
   splk_prot_array u_prot (
      .clk(clk),
      .arst_n(arst_n),
      .glob_set(glob_set),
      .glob_clr(glob_clr),
      .one_set(one_set),
      .one_clr(one_clr),
      .sel(sec_reg),
      .prot(prot)
   );

   // ------------------------------------------------------------------
   // Core domain: status
   // ------------------------------------------------------------------
   // Summary of all sectors: none, some or all protected
   always_comb begin
      if (&prot) begin
         summary = SUM_ALL;
      end else if (|prot) begin
         summary = SUM_SOME;
      end else begin
         summary = SUM_NONE;
      end
   end

   // Status byte built from live state, not from written bits
   always_comb begin
      status_next = 8'h00;
      status_next[STAT_LOCK_BIT] = lock_reg;
      status_next[STAT_WP_BIT] = wp_s2_reg; // RL9
      status_next[STAT_SUM_HI:STAT_SUM_LO] = summary; // RL9
   end

   // Registered status and lock indications
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= STAT_RST;
         hw_locked_reg <= 1'b0;
         sw_locked_reg <= 1'b0;
         ignored_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         hw_locked_reg <= hw_lock;
         sw_locked_reg <= lock_reg & wp_s2_reg; // RL17
         ignored_reg <= ignored;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign protection_regs_lock_bit = lock_reg;
   assign hw_locked = hw_locked_reg;
   assign sw_locked = sw_locked_reg;
   assign cmd_ignored = ignored_reg;
   assign status_byte1 = status_reg;
   assign sector_protected = prot; // RL19
endmodule
`default_nettype wire

/* File: verif/splk_lock_monitor.sv */
// Concurrent checks on the ports of the sector protection lock logic.
`default_nettype none
module splk_lock_monitor
   import splk_pkg::*;
(
   // Core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Serial link
   input wire logic cs_n,
   input wire logic so_oe,
   // Lock state
   input wire logic protection_regs_lock_bit,
   input wire logic hw_locked,
   input wire logic sw_locked,
   input wire logic cmd_ignored,
   // Status and protection
   input wire logic [7:0] status_byte1,
   input wire logic [SECTOR_NUM-1:0] sector_protected
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Hardware lock freezes lock bit and every sector
   property p_hw_freeze;
      hw_locked && $past(hw_locked) |-> $stable(sector_protected)
         && $stable(protection_regs_lock_bit);
   endproperty
   a_hw_freeze: assert property (p_hw_freeze)
      else $error("state moved under hardware lock");
   property p_sw_freeze;
      sw_locked && $past(sw_locked) |-> $stable(sector_protected);
   endproperty
   a_sw_freeze: assert property (p_sw_freeze)
      else $error("sectors moved under software lock");
   property p_clear_no_glob;
      $fell(protection_regs_lock_bit) |-> $stable(sector_protected);
   endproperty
   a_clear_no_glob: assert property (p_clear_no_glob)
      else $error("global operation with lock clear");
   property p_lock_states;
      (hw_locked || sw_locked) |-> !(hw_locked && sw_locked)
         && $past(protection_regs_lock_bit);
   endproperty
   a_lock_states: assert property (p_lock_states)
      else $error("lock state without lock bit");
   property p_ign_pulse;
      cmd_ignored |=> !cmd_ignored;
   endproperty
   a_ign_pulse: assert property (p_ign_pulse)
      else $error("refusal flag longer than one cycle");
   property p_oe_off;
      cs_n |-> !so_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven while deselected");
   property p_stat_fixed;
      status_byte1[6:5] == 2'h0 && status_byte1[1:0] == 2'h0;
   endproperty
   a_stat_fixed: assert property (p_stat_fixed)
      else $error("unused status bits set");
   property p_stat_sum;
      $stable(sector_protected) [*4] |-> status_byte1[3:2] ==
         ((&sector_protected) ? SUM_ALL :
         ((|sector_protected) ? SUM_SOME : SUM_NONE));
   endproperty
   a_stat_sum: assert property (p_stat_sum)
      else $error("protection summary wrong");
   property p_stat_lock;
      $stable(protection_regs_lock_bit) [*3] |->
         status_byte1[7] == protection_regs_lock_bit;
   endproperty
   a_stat_lock: assert property (p_stat_lock)
      else $error("status lock bit wrong");
endmodule

bind splk_lock_top splk_lock_monitor u_mon (.clk(clk), .arst_n(arst_n),
   .cs_n(cs_n), .so_oe(so_oe),
   .protection_regs_lock_bit(protection_regs_lock_bit),
   .hw_locked(hw_locked), .sw_locked(sw_locked), .cmd_ignored(cmd_ignored),
   .status_byte1(status_byte1), .sector_protected(sector_protected));
`default_nettype wire

/* File: verif/splk_host_model.sv */
// Host serial controller model issuing mode 0 frames.
`default_nettype none
module splk_host_model (
   // Serial link
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time HALF = 32ns;

   // Link clock stands low between frames
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // Shift nb bits out MSB first, then clock nrd bits in
   task automatic xfer(input logic [31:0] cmd, input int nb, input int nrd,
         output logic [15:0] rx, output logic oe);
      rx = '0;
      oe = 1'b1;
      #3 cs_n = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         si = cmd[i];
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
      for (int i = 0; i < nrd; i++) begin
         si = ~si;
         #HALF rx = {rx[14:0], so_o};
         oe = oe & so_oe;
         sck = 1'b1;
         #HALF sck = 1'b0;
      end
      #HALF cs_n = 1'b1;
      si = ~si;
   endtask
endmodule
`default_nettype wire

/* File: verif/splk_lock_top_tb.sv */
// Self-checking bench of the sector protection lock logic.
`default_nettype none
module splk_lock_top_tb
   import splk_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 40000;
   logic clk, arst_n, wp_n, sck, cs_n, si, so_o, so_oe, lock, hw, sw, ign;
   logic [7:0] stat;
   logic [SECTOR_NUM-1:0] prot, exp_prot;
   logic [15:0] rx;
   logic oe, exp_lock;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   int ign_seen = 0, ign_exp = 0;
   // Kind 0 stat write, 1/2 protect/unprotect, 3 read sector, 4 read
   // status, 5 pin, 6 reset, 7 cut read
   logic [11:0] steps [$] = '{12'h400, 12'h305, 12'h000, 12'h105,
      12'h305, 12'h306, 12'h400, 12'h047, 12'h400, 12'h07F, 12'h0F0,
      12'h203, 12'h000, 12'h000, 12'h0FF, 12'h00F, 12'h209, 12'h083,
      12'h500, 12'h000, 12'h101, 12'h301, 12'h400, 12'h600, 12'h70A,
      12'h20A, 12'h0F0, 12'h30A};

   splk_lock_top u_dut (.clk(clk), .arst_n(arst_n), .sck(sck),
      .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n),
      .protection_regs_lock_bit(lock), .hw_locked(hw), .sw_locked(sw),
      .cmd_ignored(ign), .status_byte1(stat), .sector_protected(prot));
   splk_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
      .so_oe(so_oe));

   // Core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Hang guard and refusal counter
   always @(posedge clk) begin
      cycles++;
      if (ign === 1'b1) ign_seen++;
      if (cycles == LIMIT) begin
         miscompares++;
         close_out();
      end
   end

   task automatic close_out();
      $display("Checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check_state();
      wait_clk(12);
      chk(prot, exp_prot);
      chk({15'h0, lock}, {15'h0, exp_lock});
      chk({14'h0, hw, sw}, {14'h0, exp_lock & ~wp_n, exp_lock & wp_n});
   endtask

   // ------------------------------------------------------------------
   // One table step: frame, pin change or reset, expectation update, comparisons
   // ------------------------------------------------------------------
   task automatic run_step(input logic [11:0] s);
      logic [3:0] k;
      logic [7:0] v, e;
      logic [23:0] a;
      k = s[11:8];
      v = s[7:0];
      a = {4'h0, v[3:0], 16'hA5C3};
      wait_clk(6);
      case (k)
         4'h0: begin
            u_host.xfer({16'h0, OPC_STAT_WR, v}, 16, 0, rx, oe);
            if (exp_lock && !wp_n) ign_exp++;
            else if (exp_lock) exp_lock = 1'b0;
            else begin
               exp_lock = v[7];
               if (v[5:2] == GLOB_UNPROT) exp_prot = '0;
               if (v[5:2] == GLOB_PROT) exp_prot = '1;
            end
            check_state();
         end
         4'h1, 4'h2: begin
            u_host.xfer({((k == 4'h1) ? OPC_PROT : OPC_UNPROT), a}, 32, 0,
               rx, oe);
            if (exp_lock) ign_exp++;
            else exp_prot[v[3:0]] = (k == 4'h1);
            check_state();
         end
         4'h3, 4'h7: begin
            u_host.xfer({OPC_RD_PROT, a}, 32, (k == 4'h3) ? 16 : 12,
               rx, oe);
            chk(rx, {16{exp_prot[v[3:0]]}} >> ((k == 4'h3) ? 0 : 4));
            chk({15'h0, oe}, 16'h1);
            wait_clk(2);
            chk({15'h0, so_oe}, 16'h0);
         end
         4'h4: begin
            u_host.xfer({24'h0, OPC_RD_STAT}, 8, 16, rx, oe);
            e = {exp_lock, 7'h00};
            e[3:2] = (&exp_prot) ? SUM_ALL :
               ((|exp_prot) ? SUM_SOME : SUM_NONE);
            chk(rx & 16'hEFEF, {2{e}});
            chk({8'h00, stat & 8'hEF}, {8'h00, e});
         end
         4'h5: begin
            wp_n = v[0];
            check_state();
         end
         default: begin
            arst_n = 1'b0;
            wait_clk(4);
            arst_n = 1'b1;
            exp_lock = 1'b0;
            exp_prot = '1;
            check_state();
         end
      endcase
   endtask

   initial begin
      arst_n = 1'b0;
      wp_n = 1'b1;
      exp_lock = 1'b0;
      exp_prot = '1;
      repeat (16) @(posedge clk);
      #1 arst_n = 1'b1;
      wait_clk(4);
      foreach (steps[i]) run_step(steps[i]);
      wait_clk(4);
      chk(ign_seen[15:0], ign_exp[15:0]);
      close_out();
   end
endmodule
`default_nettype wire
